// ==== rtl/arv_consts.svh ====
// Register map, field positions and reset values of the axis post-processing block
`ifndef ARV_CONSTS_SVH
`define ARV_CONSTS_SVH

`define ARV_ADDR_COUNTER_CONFIG   8'h00
`define ARV_ADDR_COUNTER_MODE     8'h04
`define ARV_ADDR_CORRECTION_SETUP 8'h08
`define ARV_ADDR_VIBRATION_TIMING 8'h0c
`define ARV_ADDR_COMPARE_FIRST    8'h10
`define ARV_ADDR_COMPARE_SECOND   8'h14
`define ARV_ADDR_CORR_SPEED       8'h18
`define ARV_ADDR_MOVE_SPEED       8'h1c
`define ARV_ADDR_TARGET_AMOUNT    8'h20
`define ARV_ADDR_COMMAND          8'h24
`define ARV_ADDR_STATUS           8'h28
`define ARV_ADDR_COUNTER_BASE     8'h30

`define ARV_CORR_EN_LSB       24
`define ARV_CORR_EN_MSB       27
`define ARV_RING_EN_BIT       7
`define ARV_CMP_COND_MSB      4
`define ARV_CMP_COND_LSB      2
`define ARV_CNT_SEL_MSB       1
`define ARV_CNT_SEL_LSB       0
`define ARV_SECOND_SHIFT      8
`define ARV_CMP_COND_RING     3'h0
`define ARV_SEL_FIRST         2'h0
`define ARV_SEL_SECOND        2'h1
`define ARV_CORR_AMT_MSB      11
`define ARV_CORR_AMT_LSB      0
`define ARV_METHOD_MSB        13
`define ARV_METHOD_LSB        12
`define ARV_METHOD_OFF        2'h0
`define ARV_METHOD_BACKLASH   2'h1
`define ARV_METHOD_SLIP       2'h2
`define ARV_VIB_REV_MSB       15
`define ARV_VIB_REV_LSB       0
`define ARV_VIB_FWD_MSB       31
`define ARV_VIB_FWD_LSB       16
`define ARV_VIB_UNIT_SHIFT    5
`define ARV_CMD_DIR_BIT       0
`define ARV_SPEED_RESET       16'h0001

`endif

// ==== rtl/arv_pkg.sv ====
// Types shared by the axis post-processing block
package arv_pkg;
  typedef enum logic [2:0] {
    ARV_IDLE = 3'b000,
    ARV_CORR = 3'b001,
    ARV_MOVE = 3'b010,
    ARV_VREV = 3'b011,
    ARV_VFWD = 3'b100
  } arv_state_t;
endpackage

// ==== rtl/arv_top.sv ====
// Axis ring counting, backlash/slip correction and vibration suppression
// Function
// - First counter rings when enable 1, condition 000, select 00.
// - Second counter rings when enable 1, condition 000, select 01.
// - First ring counter counting up from its compare value goes to zero.
// - First ring counter counting down from zero goes to its compare value.
// - Second ring counter counting up from its compare value goes to zero.
// - Second ring counter counting down from zero goes to its compare value.
// - Moves run fully in ring mode even if target exceeds ring range.
// - Correction pulses precede a command, at the correction speed.
// - Backlash correction happens only when direction changes from last move.
// - Slip correction happens before every command regardless of direction.
// - Correction amount is bits 11..0 of correction setup, 1 to 4095.
// - Method bits 13..12: 00 off, 01 backlash, 10 slip.
// - Counter config bits 24..27 let each counter count correction pulses.
// - After a move, one reverse then one forward pulse are added.
// - Suppression runs only when both timing values are nonzero.
// - Reverse delay is bits 15..0 of vibration timing, 32-clock units.
// - Forward delay is bits 31..16 of vibration timing, 32-clock units.
`timescale 1ns/1ns
`include "arv_consts.svh"

module arv_top
  import arv_pkg::*;
#(
  parameter int CW = 32,
  parameter int AW = 8
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rst,
  // Register port
  input  wire logic [AW-1:0] addr,
  input  wire logic [31:0]   wdata,
  input  wire logic          wr,
  input  wire logic          rd,
  output logic      [31:0]   rdata,
  // Motor driver
  output logic               pulse_out,
  output logic               dir_out,
  output logic               busy
);

  logic [31:0]       counter_config_reg;
  logic [31:0]       counter_mode_reg;
  logic [31:0]       correction_setup_reg;
  logic [31:0]       vibration_timing_reg;
  logic [CW-1:0]     compare_value_first_reg;
  logic [CW-1:0]     compare_value_second_reg;
  logic [15:0]       correction_speed_reg;
  logic [15:0]       move_speed_reg;
  logic [31:0]       target_amount_preset_reg;
  logic              cmd_pending_reg;
  logic              cmd_dir_reg;
  logic [31:0]       rdata_reg;

  arv_state_t        state_reg;
  logic              move_dir_reg;
  logic              last_dir_reg;
  logic [31:0]       remain_reg;
  logic [15:0]       ptimer_reg;
  logic [20:0]       vtimer_reg;
  logic              pulse_reg;
  logic              dir_reg;
  logic [CW-1:0]     counter_reg [4];

  logic [3:0]        corr_count_en;
  logic [1:0]        ring_mode;
  logic [11:0]       correction_amount;
  logic [1:0]        correction_method;
  logic [15:0]       reverse_pulse_delay;
  logic [15:0]       forward_pulse_delay;
  logic              vib_enable;
  logic              corr_needed;
  logic              take_cmd;
  logic              pulse_fire;
  logic              pulse_dir;
  logic [15:0]       period_now;
  logic [3:0]        count_en;

  assign corr_count_en       = counter_config_reg[`ARV_CORR_EN_MSB:`ARV_CORR_EN_LSB];
  assign correction_amount   = correction_setup_reg[`ARV_CORR_AMT_MSB:`ARV_CORR_AMT_LSB];
  assign correction_method   = correction_setup_reg[`ARV_METHOD_MSB:`ARV_METHOD_LSB];
  assign reverse_pulse_delay = vibration_timing_reg[`ARV_VIB_REV_MSB:`ARV_VIB_REV_LSB];
  assign forward_pulse_delay = vibration_timing_reg[`ARV_VIB_FWD_MSB:`ARV_VIB_FWD_LSB];

  assign ring_mode[0] = counter_mode_reg[`ARV_RING_EN_BIT]
    && (counter_mode_reg[`ARV_CMP_COND_MSB:`ARV_CMP_COND_LSB] == `ARV_CMP_COND_RING)
    && (counter_mode_reg[`ARV_CNT_SEL_MSB:`ARV_CNT_SEL_LSB] == `ARV_SEL_FIRST);
  assign ring_mode[1] = counter_mode_reg[`ARV_RING_EN_BIT + `ARV_SECOND_SHIFT]
    && (counter_mode_reg[`ARV_CMP_COND_MSB + `ARV_SECOND_SHIFT:`ARV_CMP_COND_LSB + `ARV_SECOND_SHIFT]
        == `ARV_CMP_COND_RING)
    && (counter_mode_reg[`ARV_CNT_SEL_MSB + `ARV_SECOND_SHIFT:`ARV_CNT_SEL_LSB + `ARV_SECOND_SHIFT]
        == `ARV_SEL_SECOND);

  assign vib_enable = (reverse_pulse_delay != 16'h0000) && (forward_pulse_delay != 16'h0000);

  assign corr_needed = (correction_amount != 12'h000) &&
    (((correction_method == `ARV_METHOD_BACKLASH) && (cmd_dir_reg != last_dir_reg)) ||
     (correction_method == `ARV_METHOD_SLIP));

  assign take_cmd   = (state_reg == ARV_IDLE) && cmd_pending_reg;
  // A zero speed setting would stall the axis, so it is treated as one clock per pulse
  assign period_now = (state_reg == ARV_CORR) ? correction_speed_reg : move_speed_reg;

  always_comb begin
    pulse_fire = 1'b0;
    case (state_reg)
      ARV_CORR, ARV_MOVE: pulse_fire = (ptimer_reg == 16'h0000);
      ARV_VREV, ARV_VFWD: pulse_fire = (vtimer_reg == 21'h000000) && !cmd_pending_reg;
      default:            pulse_fire = 1'b0;
    endcase
  end

  assign pulse_dir = (state_reg == ARV_VREV) ? !move_dir_reg : move_dir_reg;

  // Register writes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      counter_config_reg       <= 32'h00000000;
      counter_mode_reg         <= 32'h00000000;
      correction_setup_reg     <= 32'h00000000;
      vibration_timing_reg     <= 32'h00000000;
      compare_value_first_reg  <= '0;
      compare_value_second_reg <= '0;
      correction_speed_reg     <= `ARV_SPEED_RESET;
      move_speed_reg           <= `ARV_SPEED_RESET;
      target_amount_preset_reg <= 32'h00000000;
      cmd_dir_reg              <= 1'b0;
    end else if (wr) begin
      case (addr)
        `ARV_ADDR_COUNTER_CONFIG:   counter_config_reg       <= wdata;
        `ARV_ADDR_COUNTER_MODE:     counter_mode_reg         <= wdata;
        `ARV_ADDR_CORRECTION_SETUP: correction_setup_reg     <= wdata;
        `ARV_ADDR_VIBRATION_TIMING: vibration_timing_reg     <= wdata;
        `ARV_ADDR_COMPARE_FIRST:    compare_value_first_reg  <= wdata[CW-1:0];
        `ARV_ADDR_COMPARE_SECOND:   compare_value_second_reg <= wdata[CW-1:0];
        `ARV_ADDR_CORR_SPEED:       correction_speed_reg     <= wdata[15:0];
        `ARV_ADDR_MOVE_SPEED:       move_speed_reg           <= wdata[15:0];
        `ARV_ADDR_TARGET_AMOUNT:    target_amount_preset_reg <= wdata;
        `ARV_ADDR_COMMAND:          cmd_dir_reg              <= wdata[`ARV_CMD_DIR_BIT];
        default: begin
        end
      endcase
    end
  end

  // Command pending flag; a new write wins over the take in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cmd_pending_reg <= 1'b0;
    end else if (wr && (addr == `ARV_ADDR_COMMAND)) begin
      cmd_pending_reg <= 1'b1;
    end else if (take_cmd) begin
      cmd_pending_reg <= 1'b0;
    end
  end

  // Sequencer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg    <= ARV_IDLE;
      move_dir_reg <= 1'b0;
      last_dir_reg <= 1'b0;
      remain_reg   <= 32'h00000000;
      ptimer_reg   <= 16'h0000;
      vtimer_reg   <= 21'h000000;
    end else begin
      case (state_reg)
        ARV_IDLE: begin
          if (take_cmd) begin
            move_dir_reg <= cmd_dir_reg;
            last_dir_reg <= cmd_dir_reg;
            ptimer_reg   <= 16'h0000;
            if (corr_needed) begin
              state_reg  <= ARV_CORR;
              remain_reg <= {20'h00000, correction_amount};
            end else if (target_amount_preset_reg != 32'h00000000) begin
              state_reg  <= ARV_MOVE;
              remain_reg <= target_amount_preset_reg;
            end
          end
        end
        ARV_CORR, ARV_MOVE: begin
          if (pulse_fire) begin
            ptimer_reg <= (period_now == 16'h0000) ? 16'h0000 : period_now - 16'h0001;
            if (remain_reg == 32'h00000001) begin
              if ((state_reg == ARV_CORR) && (target_amount_preset_reg != 32'h00000000)) begin
                state_reg  <= ARV_MOVE;
                remain_reg <= target_amount_preset_reg;
                ptimer_reg <= (move_speed_reg == 16'h0000) ? 16'h0000 : move_speed_reg - 16'h0001;
              end else if (vib_enable) begin
                state_reg  <= ARV_VREV;
                vtimer_reg <= (21'(reverse_pulse_delay) << `ARV_VIB_UNIT_SHIFT) - 21'h000001;
              end else begin
                state_reg <= ARV_IDLE;
              end
            end else begin
              remain_reg <= remain_reg - 32'h00000001;
            end
          end else begin
            ptimer_reg <= ptimer_reg - 16'h0001;
          end
        end
        ARV_VREV: begin
          if (cmd_pending_reg) begin
            state_reg <= ARV_IDLE;
          end else if (pulse_fire) begin
            state_reg  <= ARV_VFWD;
            vtimer_reg <= (21'(forward_pulse_delay) << `ARV_VIB_UNIT_SHIFT) - 21'h000001;
          end else begin
            vtimer_reg <= vtimer_reg - 21'h000001;
          end
        end
        ARV_VFWD: begin
          if (cmd_pending_reg || pulse_fire) begin
            state_reg <= ARV_IDLE;
          end else begin
            vtimer_reg <= vtimer_reg - 21'h000001;
          end
        end
        default: state_reg <= ARV_IDLE;
      endcase
    end
  end

  // Pulse and direction outputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pulse_reg <= 1'b0;
      dir_reg   <= 1'b0;
    end else begin
      pulse_reg <= pulse_fire;
      if (pulse_fire) begin
        dir_reg <= pulse_dir;
      end
    end
  end

  // Position counters; the ring counters wrap, the others count freely
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_cnt
      logic          ring;
      logic [CW-1:0] cmp;
      logic [CW-1:0] cnt_next;
      assign ring = (gi < 2) && ring_mode[gi % 2];
      assign cmp  = (gi == 0) ? compare_value_first_reg : compare_value_second_reg;
      // correction pulses counted only if enabled
      assign count_en[gi] = pulse_fire && ((state_reg != ARV_CORR) || corr_count_en[gi]);
      always_comb begin
        cnt_next = counter_reg[gi];
        if (!pulse_dir) begin
          cnt_next = (ring && (counter_reg[gi] == cmp)) ? '0 : counter_reg[gi] + 1'b1;
        end else begin
          cnt_next = (ring && (counter_reg[gi] == '0)) ? cmp : counter_reg[gi] - 1'b1;
        end
      end
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          counter_reg[gi] <= '0;
        end else if (count_en[gi]) begin
          counter_reg[gi] <= cnt_next;
        end
      end
    end
  endgenerate

  // Read path; configuration registers are write-only and read as zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_reg <= 32'h00000000;
    end else if (rd) begin
      case (addr)
        `ARV_ADDR_STATUS:
          rdata_reg <= {24'h000000, ring_mode, cmd_pending_reg, last_dir_reg, busy, state_reg};
        `ARV_ADDR_COUNTER_BASE:           rdata_reg <= 32'(counter_reg[0]);
        `ARV_ADDR_COUNTER_BASE + 8'h04:   rdata_reg <= 32'(counter_reg[1]);
        `ARV_ADDR_COUNTER_BASE + 8'h08:   rdata_reg <= 32'(counter_reg[2]);
        `ARV_ADDR_COUNTER_BASE + 8'h0c:   rdata_reg <= 32'(counter_reg[3]);
        default:                          rdata_reg <= 32'h00000000;
      endcase
    end else begin
      rdata_reg <= 32'h00000000;
    end
  end

  assign rdata     = rdata_reg;
  assign pulse_out = pulse_reg;
  assign dir_out   = dir_reg;
  assign busy      = (state_reg != ARV_IDLE);

  // Checks
  sequence s_rev_pulse;
    pulse_fire && (state_reg == ARV_VREV);
  endsequence

  sequence s_fwd_pulse;
    pulse_fire && (state_reg == ARV_VFWD) && (pulse_dir == move_dir_reg);
  endsequence

  a_ring_up_first: assert property (@(posedge clk) disable iff (rst)
    count_en[0] && ring_mode[0] && !pulse_dir && (counter_reg[0] == compare_value_first_reg)
    |=> counter_reg[0] == '0)
    else $error("first ring counter did not wrap to zero");

  a_ring_down_second: assert property (@(posedge clk) disable iff (rst)
    count_en[1] && ring_mode[1] && pulse_dir && (counter_reg[1] == '0)
    |=> counter_reg[1] == $past(compare_value_second_reg))
    else $error("second ring counter did not wrap to compare value");

  a_corr_gate: assert property (@(posedge clk) disable iff (rst)
    (state_reg == ARV_CORR) && pulse_fire && !corr_count_en[2] |=> $stable(counter_reg[2]))
    else $error("correction pulse counted while disabled");

  a_vib_needs_both: assert property (@(posedge clk) disable iff (rst)
    $changed(state_reg) && (state_reg == ARV_VREV) |-> $past(vib_enable))
    else $error("suppression ran with a zero timing");

  a_vib_order: assert property (@(posedge clk) disable iff (rst)
    s_rev_pulse |=> (state_reg == ARV_VFWD) && !pulse_fire)
    else $error("forward suppression pulse not delayed");

  a_rev_dir: assert property (@(posedge clk) disable iff (rst)
    s_rev_pulse |=> pulse_out && (dir_out != move_dir_reg))
    else $error("reverse suppression pulse wrong");

  a_fwd_ends: assert property (@(posedge clk) disable iff (rst)
    s_fwd_pulse |=> state_reg == ARV_IDLE)
    else $error("sequencer not idle after forward pulse");

  a_slip_always: assert property (@(posedge clk) disable iff (rst)
    take_cmd && (correction_method == `ARV_METHOD_SLIP) && (correction_amount != 12'h000)
    |=> state_reg == ARV_CORR)
    else $error("slip correction skipped");

  a_backlash_skip: assert property (@(posedge clk) disable iff (rst)
    take_cmd && (correction_method == `ARV_METHOD_BACKLASH) && (cmd_dir_reg == last_dir_reg)
    |=> state_reg != ARV_CORR)
    else $error("backlash correction without reversal");

  a_pulse_out: assert property (@(posedge clk) disable iff (rst)
    pulse_fire |=> pulse_out && (dir_out == $past(pulse_dir)))
    else $error("pulse output does not follow the pulse event");

endmodule

// ==== testbench/arv_motor_model.sv ====
// Motor driver model: counts step pulses by direction and times their spacing
`timescale 1ns/1ns

module arv_motor_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Step interface from the axis block
  input  wire logic        pulse_out,
  input  wire logic        dir_out,
  // Observations for the bench
  output logic      [31:0] fwd_cnt,
  output logic      [31:0] rev_cnt,
  output logic      [31:0] gap,
  output logic      [31:0] rev_gap
);
  logic [31:0] cyc_reg;
  logic [31:0] last_reg;

  // Direction is latched with each step, as a real driver does
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cyc_reg  <= 32'h0;
      last_reg <= 32'h0;
      fwd_cnt  <= 32'h0;
      rev_cnt  <= 32'h0;
      gap      <= 32'h0;
      rev_gap  <= 32'h0;
    end else begin
      cyc_reg <= cyc_reg + 32'h1;
      if (pulse_out) begin
        last_reg <= cyc_reg;
        gap      <= cyc_reg - last_reg;
        if (dir_out) begin
          rev_cnt <= rev_cnt + 32'h1;
          rev_gap <= cyc_reg - last_reg;
        end else begin
          fwd_cnt <= fwd_cnt + 32'h1;
        end
      end
    end
  end
endmodule

// ==== testbench/axis_ring_correction_vibration_bench.sv ====
// Register-driven bench for ring counting, correction and vibration suppression
`timescale 1ns/1ns
`include "arv_consts.svh"

module axis_ring_correction_vibration_bench;
  logic        clk;
  logic        rst;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic        pulse_out;
  logic        dir_out;
  logic        busy;
  logic [31:0] fwd_cnt;
  logic [31:0] rev_cnt;
  logic [31:0] gap;
  logic [31:0] rev_gap;
  logic [31:0] exp_c [4];
  logic [3:0]  corr_en;
  int          mismatches;
  int          tests_run;

  arv_top arv_top_inst (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .pulse_out(pulse_out), .dir_out(dir_out), .busy(busy)
  );

  arv_motor_model arv_motor_model_inst (
    .clk(clk), .rst(rst), .pulse_out(pulse_out), .dir_out(dir_out),
    .fwd_cnt(fwd_cnt), .rev_cnt(rev_cnt), .gap(gap), .rev_gap(rev_gap)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic tally_and_finish();
    $display("Checks run %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic rd_check(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    rd_reg(a, v);
    check(v, e);
  endtask

  task automatic check_counters();
    for (int i = 0; i < 4; i++) begin
      rd_check(`ARV_ADDR_COUNTER_BASE + 8'(4 * i), exp_c[i]);
    end
  endtask

  // One command; pulse counts seen by the driver must match, and the counter model is advanced
  task automatic move(input logic d, input logic [31:0] n, input logic [31:0] nc, input logic [31:0] nv);
    logic [31:0] f0;
    logic [31:0] r0;
    int          k;
    f0 = fwd_cnt;
    r0 = rev_cnt;
    wr_reg(`ARV_ADDR_TARGET_AMOUNT, n);
    wr_reg(`ARV_ADDR_COMMAND, {31'h0, d});
    repeat (3) @(posedge clk);
    k = 0;
    while (busy !== 1'b0 && k < 20000) begin
      @(posedge clk);
      #1 k++;
    end
    if (k == 20000) begin
      mismatches++;
      tally_and_finish();
    end
    // The last step leaves the output flop on the edge the sequencer idles; the driver counts it one cycle later
    repeat (2) @(posedge clk);
    #1;
    check(fwd_cnt - f0, (d ? 32'h0 : n + nc) + nv);
    check(rev_cnt - r0, (d ? n + nc : 32'h0) + nv);
    for (int i = 0; i < 4; i++) begin
      if (d) exp_c[i] = exp_c[i] - n - (corr_en[i] ? nc : 32'h0);
      else exp_c[i] = exp_c[i] + n + (corr_en[i] ? nc : 32'h0);
    end
  endtask

  initial begin
    rst = 1'b1;
    addr = 8'h0;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    mismatches = 0;
    tests_run = 0;
    corr_en = 4'h0;
    for (int i = 0; i < 4; i++) exp_c[i] = 32'h0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd_check(`ARV_ADDR_STATUS, 32'h0);
    rd_check(`ARV_ADDR_CORRECTION_SETUP, 32'h0);
    rd_check(8'hfc, 32'h0);
    move(1'b0, 32'h3, 32'h0, 32'h0);
    check_counters();
    // Compare values chosen so both counters already sit in range
    wr_reg(`ARV_ADDR_COMPARE_FIRST, 32'h4);
    wr_reg(`ARV_ADDR_COMPARE_SECOND, 32'h3);
    wr_reg(`ARV_ADDR_COUNTER_MODE, 32'h0000_8184);
    rd_check(`ARV_ADDR_STATUS, 32'h0000_0080);
    // Ring counters get condition 000
    wr_reg(`ARV_ADDR_COUNTER_MODE, 32'h0000_8180);
    rd_check(`ARV_ADDR_STATUS, 32'h0000_00c0);
    move(1'b0, 32'h7, 32'h0, 32'h0);
    exp_c[0] = 32'h0;
    exp_c[1] = 32'h2;
    check_counters();
    move(1'b1, 32'h3, 32'h0, 32'h0);
    exp_c[0] = 32'h2;
    exp_c[1] = 32'h3;
    check_counters();
    wr_reg(`ARV_ADDR_COUNTER_MODE, 32'h0);
    wr_reg(`ARV_ADDR_CORR_SPEED, 32'h3);
    corr_en = 4'b0101;
    wr_reg(`ARV_ADDR_COUNTER_CONFIG, {4'h0, corr_en, 24'h0});
    wr_reg(`ARV_ADDR_CORRECTION_SETUP, 32'h0000_1002);
    move(1'b1, 32'h1, 32'h0, 32'h0);
    move(1'b0, 32'h0, 32'h2, 32'h0);
    check(gap, 32'h3);
    move(1'b0, 32'h0, 32'h0, 32'h0);
    wr_reg(`ARV_ADDR_CORRECTION_SETUP, 32'h0000_2003);
    move(1'b0, 32'h0, 32'h3, 32'h0);
    move(1'b1, 32'h1, 32'h3, 32'h0);
    wr_reg(`ARV_ADDR_CORRECTION_SETUP, 32'h0000_2fff);
    move(1'b0, 32'h0, 32'hfff, 32'h0);
    wr_reg(`ARV_ADDR_CORRECTION_SETUP, 32'h0000_0003);
    move(1'b1, 32'h1, 32'h0, 32'h0);
    check_counters();
    wr_reg(`ARV_ADDR_CORRECTION_SETUP, 32'h0);
    wr_reg(`ARV_ADDR_VIBRATION_TIMING, 32'h0002_0001);
    move(1'b0, 32'h2, 32'h0, 32'h1);
    check(rev_gap, 32'h20);
    check(gap, 32'h40);
    wr_reg(`ARV_ADDR_VIBRATION_TIMING, 32'h0005_0000);
    move(1'b0, 32'h1, 32'h0, 32'h0);
    // A new command during the reverse wait must cancel that suppression
    wr_reg(`ARV_ADDR_VIBRATION_TIMING, 32'h0001_0004);
    wr_reg(`ARV_ADDR_TARGET_AMOUNT, 32'h1);
    wr_reg(`ARV_ADDR_COMMAND, 32'h0);
    repeat (10) @(posedge clk);
    move(1'b0, 32'h1, 32'h0, 32'h1);
    for (int i = 0; i < 4; i++) exp_c[i] = exp_c[i] + 32'h1;
    check_counters();
    tally_and_finish();
  end
endmodule
